//--- getf_params.svh
// Constants of the epoch time formatter: offsets, fields, reset values, timing counts
`ifndef GETF_PARAMS_SVH
`define GETF_PARAMS_SVH

// Timing
`define GETF_CLK_PERIOD_NS      8
`define GETF_TICK_PERIOD_MS     1
`define GETF_TICK_CYCLES        ((`GETF_TICK_PERIOD_MS * 1000000) / `GETF_CLK_PERIOD_NS)
`define GETF_NOM_TICKS          11'h3E8
`define GETF_SHORT_TICKS        11'h3E7
`define GETF_LONG_TICKS         11'h3E9
`define GETF_TICK_NS            32'sh000F4240
`define GETF_HALF_TICK_NS       32'sh0007A120
`define GETF_EPOCH_MS           32'h000003E8
`define GETF_WEEK_MS            32'h240C8400
`define GETF_NS_PER_CS          31'h00989680
`define GETF_HALF_CS_NS         31'h004C4B40
`define GETF_NS_PER_S           32'sh3B9ACA00
`define GETF_CS_CARRY           7'h64
`define GETF_DEFAULT_LEAP       9'h000

// Register word indexes
`define GETF_REG_CTRL           8'h00
`define GETF_REG_BIAS           8'h01
`define GETF_REG_TOW            8'h02
`define GETF_REG_WEEK           8'h03
`define GETF_REG_BCAST_LEAP     8'h04
`define GETF_REG_AID_LEAP       8'h05
`define GETF_REG_LEAP_PEND      8'h06
`define GETF_REG_CAL_DATE       8'h07
`define GETF_REG_CAL_TIME       8'h08
`define GETF_REG_SUBSEC         8'h09
`define GETF_REG_CHECK          8'h0A
`define GETF_REG_STATUS         8'h10
`define GETF_REG_TOW_RD         8'h11
`define GETF_REG_WEEK_RD        8'h12
`define GETF_REG_CAL_RD         8'h13
`define GETF_REG_OFFSET_RD      8'h14

// Field positions
`define GETF_CTRL_RUN           0
`define GETF_CTRL_COMPAT        1
`define GETF_CTRL_AID_SEL       2
`define GETF_CTRL_GLONASS       3
`define GETF_LEAP_VALID         31
`define GETF_PEND_ADD           0
`define GETF_PEND_REMOVE        1
`define GETF_PEND_JUNE          2
`define GETF_CALT_TIME_OK       31
`define GETF_CALT_DATE_OK       30

// Reset values
`define GETF_CTRL_RESET         32'h00000000
`define GETF_CAL_RESET_YEAR     12'h7B2
`endif

//--- getf_pkg.sv
// Types shared by the epoch time formatter
package getf_pkg;

  typedef struct packed {
    logic [11:0] year;
    logic [3:0]  month;
    logic [4:0]  day;
    logic [4:0]  hour;
    logic [5:0]  min;
    logic [5:0]  sec;
  } getf_cal_s;

  typedef struct packed {
    logic date_known_flag;
    logic time_known_flag;
    logic date_checked_flag;
    logic time_checked_flag;
    logic check_available_flag;
    logic whole_second_resolved_flag;
  } getf_flags_s;

  typedef struct packed {
    logic [31:0]        epoch_week_time_stamp;
    logic [15:0]        week;
    getf_cal_s          utc;
    logic signed [31:0] nano;
    logic [6:0]         centisec;
    getf_flags_s        flags;
  } getf_report_s;

  typedef struct packed {
    logic [9:0][7:0] chars;
    logic [3:0]      len;
  } getf_sentence_s;

  typedef enum logic {
    PH_IDLE  = 1'b0,
    PH_ROUND = 1'b1
  } getf_phase_e;

endpackage

//--- getf_round.sv
// Iterative rounding of a sub-second fraction to hundredths
`timescale 1ns/1ps
`include "getf_params.svh"
module getf_round (
  input  wire logic               i_ref_clk,
  input  wire logic               i_resetn,
  input  wire logic               i_start,
  input  wire logic [29:0]        i_frac,
  output logic                    o_done,
  output logic [6:0]              o_cs,
  output logic                    o_carry,
  output logic signed [31:0]      o_nano
);

  logic [30:0] rem_q;
  logic [29:0] frac_q;
  logic [6:0]  cnt_q;
  logic        busy_q;
  wire         more = rem_q >= `GETF_NS_PER_CS;
  wire         carry = cnt_q == `GETF_CS_CARRY;

  // One subtraction per cycle; at most 108 cycles, far inside an epoch
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rem_q   <= 31'h00000000;
      frac_q  <= 30'h00000000;
      cnt_q   <= 7'h00;
      busy_q  <= 1'b0;
      o_done  <= 1'b0;
      o_cs    <= 7'h00;
      o_carry <= 1'b0;
      o_nano  <= 32'sh00000000;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_start)
      begin
        rem_q  <= {1'b0, i_frac} + `GETF_HALF_CS_NS;
        frac_q <= i_frac;
        cnt_q  <= 7'h00;
        busy_q <= 1'b1;
      end
      else if (busy_q && more)
      begin
        rem_q <= rem_q - `GETF_NS_PER_CS;
        cnt_q <= cnt_q + 7'h01;
      end
      else if (busy_q)
      begin
        busy_q  <= 1'b0;
        o_done  <= 1'b1;
        o_carry <= carry;
        o_cs    <= carry ? 7'h00 : cnt_q;
        o_nano  <= carry ? $signed({2'b00, frac_q}) - `GETF_NS_PER_S : $signed({2'b00, frac_q});
      end
    end
  end

endmodule

//--- getf_top.sv
// Epoch scheduler, GPS/UTC time keeping and report formatter
//
// How it works
// - Epoch is the reference tick nearest wanted time
// - 1000 ticks per epoch, 999/1001 to steer
// - Every solution yields GPS and UTC time
// - Leap count from broadcast or aiding word
// - Missing conversion data: default offset, known and checked flags cleared
// - One stamp shared by all epoch reports
// - Known flags only when date/time known
// - Checked flags only after independent check
// - Resolved only with leap count or GLONASS
// - Sentence time rounded, two fractional digits
// - Compat mode adds third digit, always zero
// - Integer fields equal sentence fields
// - Signed nanosecond correction within documented range
// - Rounding carry ripples into date, nano negative
// - Positive leap: 23:59:59, 23:59:60, 00:00:00
// - Negative leap: 23:59:58 straight to 00:00:00
// - Leap only end of year or 30 June
// - Clock divided to 1 kHz reference tick
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "getf_params.svh"
module getf_top #(
  parameter int TICK_CYCLES = `GETF_TICK_CYCLES
) (
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_resetn,
  input  wire logic [7:0]              i_addr,
  input  wire logic [31:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic [31:0]                  o_rdata,
  output logic                         o_tick,
  output logic                         o_epoch,
  output getf_pkg::getf_report_s       o_report,
  output getf_pkg::getf_sentence_s     o_sentence,
  output logic                         o_report_valid
);

  localparam int TW = $clog2(TICK_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Calendar helpers

  function automatic logic [4:0] days_in(input logic [11:0] y, input logic [3:0] m);
    logic leap;
    leap = (y[1:0] == 2'b00) && (((y % 12'h064) != 12'h000) || ((y % 12'h190) == 12'h000));
    if (m == 4'h2)
      days_in = leap ? 5'h1D : 5'h1C;
    else if (m == 4'h4 || m == 4'h6 || m == 4'h9 || m == 4'hB)
      days_in = 5'h1E;
    else
      days_in = 5'h1F;
  endfunction

  function automatic getf_pkg::getf_cal_s next_sec(input getf_pkg::getf_cal_s c, input logic ins,
                                                   input logic rem, input logic last);
    getf_pkg::getf_cal_s n;
    n = c;
    // Positive leap
    if (last && ins && c.sec == 6'h3B)
      n.sec = 6'h3C;
    // Rollover to second 0, also the negative leap
    else if (c.sec == 6'h3B || c.sec == 6'h3C || (last && rem && c.sec == 6'h3A))
    begin
      n.sec = 6'h00;
      if (c.min != 6'h3B)
        n.min = c.min + 6'h01;
      else
      begin
        n.min = 6'h00;
        if (c.hour != 5'h17)
          n.hour = c.hour + 5'h01;
        else
        begin
          n.hour = 5'h00;
          if (c.day != days_in(c.year, c.month))
            n.day = c.day + 5'h01;
          else
          begin
            n.day = 5'h01;
            n.month = (c.month == 4'hC) ? 4'h1 : c.month + 4'h1;
            n.year = (c.month == 4'hC) ? c.year + 12'h001 : c.year;
          end
        end
      end
    end
    else
      n.sec = c.sec + 6'h01;
    next_sec = n;
  endfunction

  function automatic getf_pkg::getf_cal_s prev_sec(input getf_pkg::getf_cal_s c);
    getf_pkg::getf_cal_s p;
    p = c;
    if (c.sec != 6'h00)
      p.sec = c.sec - 6'h01;
    else
    begin
      p.sec = 6'h3B;
      if (c.min != 6'h00)
        p.min = c.min - 6'h01;
      else
      begin
        p.min = 6'h3B;
        if (c.hour != 5'h00)
          p.hour = c.hour - 5'h01;
        else
        begin
          p.hour = 5'h17;
          if (c.day != 5'h01)
            p.day = c.day - 5'h01;
          else
          begin
            p.month = (c.month == 4'h1) ? 4'hC : c.month - 4'h1;
            p.year = (c.month == 4'h1) ? c.year - 12'h001 : c.year;
            p.day = days_in(p.year, p.month);
          end
        end
      end
    end
    prev_sec = p;
  endfunction

  function automatic logic [15:0] ascii2(input logic [6:0] v);
    logic [6:0] t;
    logic [6:0] o;
    t = v / 7'h0A;
    o = v % 7'h0A;
    ascii2 = {8'h30 + {1'b0, t}, 8'h30 + {1'b0, o}};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [31:0]         ctrl_q;
  logic signed [31:0]  bias_q;
  logic [31:0]         tow_stage_q;
  logic [31:0]         tow_q;
  logic [15:0]         week_q;
  logic [31:0]         bcast_q;
  logic [31:0]         aid_q;
  logic [2:0]          pend_q;
  logic [31:0]         date_stage_q;
  logic [29:0]         subsec_q;
  logic [2:0]          check_q;
  logic                date_ok_q;
  logic                time_ok_q;
  getf_pkg::getf_cal_s cal_q;
  getf_pkg::getf_cal_s cal_d;
  logic signed [8:0]   applied_q;
  logic [TW-1:0]       div_q;
  logic [10:0]         tick_n_q;
  logic [10:0]         interval_q;
  getf_pkg::getf_phase_e phase_q;

  wire wr_ctrl   = i_wr && i_addr == `GETF_REG_CTRL;
  wire wr_bias   = i_wr && i_addr == `GETF_REG_BIAS;
  wire wr_week   = i_wr && i_addr == `GETF_REG_WEEK;
  wire wr_pend   = i_wr && i_addr == `GETF_REG_LEAP_PEND;
  wire wr_caltim = i_wr && i_addr == `GETF_REG_CAL_TIME;

  ////////////////////////////////////////////////////////////////////////////
  // Tick divider and epoch scheduling

  // Reference tick
  // divide to 1 kHz
  wire tick = div_q == TICK_LAST;
  wire run = ctrl_q[`GETF_CTRL_RUN];
  // Epoch on tick
  // epoch is a tick
  wire epoch = tick && run && (tick_n_q == interval_q - 11'h001);

  // Steering choice: residual bias beyond half a tick moves the next epoch one tick
  // 999/1001 steering
  wire bias_hi = bias_q > `GETF_HALF_TICK_NS;
  wire bias_lo = bias_q < -`GETF_HALF_TICK_NS;
  wire [10:0] next_interval = bias_hi ? `GETF_LONG_TICKS : (bias_lo ? `GETF_SHORT_TICKS : `GETF_NOM_TICKS);

  ////////////////////////////////////////////////////////////////////////////
  // Conversion state

  // Offset source
  // broadcast or aiding
  wire [31:0] src_leap = ctrl_q[`GETF_CTRL_AID_SEL] ? aid_q : bcast_q;
  wire        info_ok = src_leap[`GETF_LEAP_VALID];
  // Default offset when the selected source word is not valid
  // default offset
  wire signed [8:0] wanted = info_ok ? $signed(src_leap[8:0]) : $signed(`GETF_DEFAULT_LEAP);

  // Leap window
  // end of year or 30 June
  wire elig_day = (cal_q.month == 4'hC && cal_q.day == 5'h1F) ||
                  (pend_q[`GETF_PEND_JUNE] && cal_q.month == 4'h6 && cal_q.day == 5'h1E);
  wire last_min = elig_day && cal_q.hour == 5'h17 && cal_q.min == 6'h3B;
  wire ins = pend_q[`GETF_PEND_ADD];
  wire rem = pend_q[`GETF_PEND_REMOVE];
  wire leap_add_done = epoch && last_min && ins && cal_q.sec == 6'h3C;
  wire leap_rem_done = epoch && last_min && rem && cal_q.sec == 6'h3A;

  // Calendar steps to the wanted offset one second per cycle between epochs
  // GPS to UTC conversion
  wire step_ok = phase_q == getf_pkg::PH_IDLE && !epoch && !wr_caltim && applied_q != wanted;
  wire step_back = applied_q < wanted;

  always_comb
  begin
    cal_d = cal_q;
    if (wr_caltim)
      cal_d = '{year: date_stage_q[27:16], month: date_stage_q[11:8], day: date_stage_q[4:0],
                hour: i_wdata[20:16], min: i_wdata[13:8], sec: i_wdata[5:0]};
    else if (epoch)
      cal_d = next_sec(cal_q, ins, rem, last_min);
    else if (step_ok)
      cal_d = step_back ? prev_sec(cal_q) : next_sec(cal_q, 1'b0, 1'b0, 1'b0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rounding and report assembly

  logic               rnd_done;
  logic [6:0]         rnd_cs;
  logic               rnd_carry;
  logic signed [31:0] rnd_nano;

  getf_round u_round (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_start   (epoch),
    .i_frac    (subsec_q),
    .o_done    (rnd_done),
    .o_cs      (rnd_cs),
    .o_carry   (rnd_carry),
    .o_nano    (rnd_nano)
  );

  // Carry of the rounding ripples through the whole date
  // carry into date
  wire getf_pkg::getf_cal_s rep_cal = rnd_carry ? next_sec(cal_q, ins, rem, last_min) : cal_q;

  wire getf_pkg::getf_flags_s flags = '{
    date_known_flag:            date_ok_q && info_ok,
    time_known_flag:            time_ok_q && info_ok,
    date_checked_flag:          check_q[0] && date_ok_q && info_ok,
    time_checked_flag:          check_q[1] && time_ok_q && info_ok,
    check_available_flag:       check_q[2],
    whole_second_resolved_flag: time_ok_q && (info_ok || ctrl_q[`GETF_CTRL_GLONASS])
  };

  // Same fields feed both the binary report and the sentence text
  // fields match text
  wire compat = ctrl_q[`GETF_CTRL_COMPAT];
  wire [15:0] hh = ascii2({2'b00, rep_cal.hour});
  wire [15:0] mm = ascii2({1'b0, rep_cal.min});
  wire [15:0] ss = ascii2({1'b0, rep_cal.sec});
  wire [15:0] cc = ascii2(rnd_cs);
  wire getf_pkg::getf_sentence_s sent = '{chars: {hh, mm, ss, 8'h2E, cc, compat ? 8'h30 : 8'h20},
                                          len: compat ? 4'hA : 4'h9};

  ////////////////////////////////////////////////////////////////////////////
  // Read decode

  logic [31:0] rd_mux;
  always_comb
  begin
    unique case (i_addr)
      `GETF_REG_CTRL:      rd_mux = ctrl_q;
      `GETF_REG_BIAS:      rd_mux = bias_q;
      `GETF_REG_BCAST_LEAP:rd_mux = bcast_q;
      `GETF_REG_AID_LEAP:  rd_mux = aid_q;
      `GETF_REG_LEAP_PEND: rd_mux = {29'h00000000, pend_q};
      `GETF_REG_SUBSEC:    rd_mux = {2'b00, subsec_q};
      `GETF_REG_CHECK:     rd_mux = {29'h00000000, check_q};
      `GETF_REG_STATUS:    rd_mux = {25'h0000000, phase_q, flags};
      `GETF_REG_TOW_RD:    rd_mux = tow_q;
      `GETF_REG_WEEK_RD:   rd_mux = {16'h0000, week_q};
      `GETF_REG_CAL_RD:    rd_mux = {cal_q.year[5:0], cal_q.month, cal_q.day, cal_q.hour, cal_q.min, cal_q.sec};
      `GETF_REG_OFFSET_RD: rd_mux = {{23{applied_q[8]}}, applied_q};
      default:             rd_mux = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ctrl_q       <= `GETF_CTRL_RESET;
      tow_stage_q  <= 32'h00000000;
      bcast_q      <= 32'h00000000;
      aid_q        <= 32'h00000000;
      date_stage_q <= 32'h00000000;
      subsec_q     <= 30'h00000000;
      check_q      <= 3'h0;
      o_rdata      <= 32'h00000000;
    end
    else
    begin
      if (wr_ctrl) ctrl_q <= i_wdata;
      if (i_wr && i_addr == `GETF_REG_TOW) tow_stage_q <= i_wdata;
      if (i_wr && i_addr == `GETF_REG_BCAST_LEAP) bcast_q <= i_wdata;
      if (i_wr && i_addr == `GETF_REG_AID_LEAP) aid_q <= i_wdata;
      if (i_wr && i_addr == `GETF_REG_CAL_DATE) date_stage_q <= i_wdata;
      if (i_wr && i_addr == `GETF_REG_SUBSEC) subsec_q <= i_wdata[29:0];
      if (i_wr && i_addr == `GETF_REG_CHECK) check_q <= i_wdata[2:0];
      o_rdata <= i_rd ? rd_mux : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time keeping

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      div_q      <= '0;
      tick_n_q   <= 11'h000;
      interval_q <= `GETF_NOM_TICKS;
      bias_q     <= 32'sh00000000;
      tow_q      <= 32'h00000000;
      week_q     <= 16'h0000;
      pend_q     <= 3'h0;
      date_ok_q  <= 1'b0;
      time_ok_q  <= 1'b0;
      cal_q      <= '{year: `GETF_CAL_RESET_YEAR, month: 4'h1, day: 5'h01, hour: 5'h00, min: 6'h00, sec: 6'h00};
      applied_q  <= 9'sh000;
      phase_q    <= getf_pkg::PH_IDLE;
    end
    else
    begin
      div_q <= tick ? '0 : div_q + TW'(1);
      if (!run || epoch)
        tick_n_q <= 11'h000;
      else if (tick)
        tick_n_q <= tick_n_q + 11'h001;
      if (epoch)
        interval_q <= next_interval;
      // Software write wins over the steering update
      if (wr_bias)
        bias_q <= i_wdata;
      else if (epoch && bias_hi)
        bias_q <= bias_q - `GETF_TICK_NS;
      else if (epoch && bias_lo)
        bias_q <= bias_q + `GETF_TICK_NS;
      if (wr_week)
      begin
        tow_q  <= tow_stage_q;
        week_q <= i_wdata[15:0];
      end
      else if (epoch)
      begin
        tow_q  <= (tow_q + `GETF_EPOCH_MS >= `GETF_WEEK_MS) ? tow_q + `GETF_EPOCH_MS - `GETF_WEEK_MS
                                                           : tow_q + `GETF_EPOCH_MS;
        week_q <= (tow_q + `GETF_EPOCH_MS >= `GETF_WEEK_MS) ? week_q + 16'h0001 : week_q;
      end
      // Announcement write wins over the clear when the leap passes
      if (wr_pend)
        pend_q <= i_wdata[2:0];
      else if (leap_add_done || leap_rem_done)
        pend_q <= 3'h0;
      cal_q <= cal_d;
      if (wr_caltim)
      begin
        date_ok_q <= i_wdata[`GETF_CALT_DATE_OK];
        time_ok_q <= i_wdata[`GETF_CALT_TIME_OK];
        applied_q <= 9'sh000;
      end
      else if (leap_add_done)
        applied_q <= applied_q + 9'sh001;
      else if (leap_rem_done)
        applied_q <= applied_q - 9'sh001;
      else if (step_ok)
        applied_q <= step_back ? applied_q + 9'sh001 : applied_q - 9'sh001;
      unique case (phase_q)
        getf_pkg::PH_IDLE:  if (epoch) phase_q <= getf_pkg::PH_ROUND;
        getf_pkg::PH_ROUND: if (rnd_done) phase_q <= getf_pkg::PH_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_tick         <= 1'b0;
      o_epoch        <= 1'b0;
      o_report       <= '0;
      o_sentence     <= '0;
      o_report_valid <= 1'b0;
    end
    else
    begin
      o_tick         <= tick;
      o_epoch        <= epoch;
      o_report_valid <= rnd_done;
      if (rnd_done)
      begin
        o_report   <= '{epoch_week_time_stamp: tow_q, week: week_q, utc: rep_cal,
                        nano: rnd_nano, centisec: rnd_cs, flags: flags};
        o_sentence <= sent;
      end
    end
  end

endmodule

//--- getf_props.sv
// Concurrent checks on tick, epoch, report and sentence outputs
`timescale 1ns/1ps
module getf_props #(
  parameter int TICK_CYCLES = 8
) (
  input wire logic                     i_ref_clk,
  input wire logic                     i_resetn,
  input wire logic                     o_tick,
  input wire logic                     o_epoch,
  input wire getf_pkg::getf_report_s   o_report,
  input wire getf_pkg::getf_sentence_s o_sentence,
  input wire logic                     o_report_valid
);
  logic [16:0] cyc_q;
  logic [10:0] gap_q;
  logic [7:0]  age_q;
  logic        tseen_q;
  logic        eseen_q;

  // Age saturates so that a report with no epoch behind it is caught
  always_ff @(posedge i_ref_clk or negedge i_resetn)
    if (!i_resetn)
    begin
      cyc_q   <= '0;
      tseen_q <= 1'b0;
      age_q   <= 8'hFF;
    end
    else
    begin
      cyc_q   <= o_tick ? '0 : cyc_q + 17'h00001;
      tseen_q <= tseen_q | o_tick;
      age_q   <= o_epoch ? 8'h00 : age_q + {7'h00, age_q != 8'hFF};
    end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
    if (!i_resetn)
    begin
      gap_q   <= '0;
      eseen_q <= 1'b0;
    end
    else if (o_tick)
    begin
      gap_q   <= o_epoch ? '0 : gap_q + 11'h001;
      eseen_q <= eseen_q | o_epoch;
    end

////////////////////////////////////////
  default clocking dc @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence report_out_s;
    ##[2:110] o_report_valid;
  endsequence
  sequence leap_sec_s;
    o_report_valid && o_report.utc.sec == 6'h3C;
  endsequence

  epoch_on_tick_a: assert property (o_epoch |-> o_tick)
    else $error("epoch without tick");
  tick_period_a: assert property (o_tick && tseen_q |-> cyc_q == TICK_CYCLES - 1)
    else $error("tick period wrong");
  epoch_gap_a: assert property (o_epoch && eseen_q |-> gap_q inside {[998:1000]})
    else $error("ticks between epochs wrong");
  report_after_a: assert property (o_epoch |-> report_out_s)
    else $error("no report after epoch");
  report_cause_a: assert property (o_report_valid |-> age_q <= 8'h6E)
    else $error("report without epoch");
  report_hold_a: assert property (!o_report_valid |-> $stable(o_report))
    else $error("report changed between epochs");
  nano_range_a: assert property (o_report_valid |-> $signed(o_report.nano) >= -32'sh004C4B40
    && $signed(o_report.nano) <= 32'sh3B4E7EBF)
    else $error("nano out of range");
  carry_zero_a: assert property (o_report_valid && $signed(o_report.nano) < 0 |-> o_report.centisec == 7'h00)
    else $error("negative nano with nonzero hundredths");
  compat_digit_a: assert property (o_report_valid && o_sentence.len == 4'hA |-> o_sentence.chars[0] == 8'h30)
    else $error("third digit not zero");
  sec_digits_a: assert property (o_report_valid |-> o_sentence.chars[5] == 8'h30 + 8'(o_report.utc.sec / 6'h0A)
    && o_sentence.chars[4] == 8'h30 + 8'(o_report.utc.sec % 6'h0A))
    else $error("sentence seconds differ");
  cs_digits_a: assert property (o_report_valid |-> o_sentence.chars[2] == 8'h30 + 8'(o_report.centisec / 7'h0A)
    && o_sentence.chars[1] == 8'h30 + 8'(o_report.centisec % 7'h0A))
    else $error("sentence hundredths differ");
  leap_place_a: assert property (leap_sec_s |-> o_report.utc.hour == 5'h17 && o_report.utc.min == 6'h3B
    && ((o_report.utc.month == 4'hC && o_report.utc.day == 5'h1F)
    || (o_report.utc.month == 4'h6 && o_report.utc.day == 5'h1E)))
    else $error("second 60 outside leap minute");
  checked_known_a: assert property (o_report_valid |-> o_report.flags.date_known_flag
    || !o_report.flags.date_checked_flag)
    else $error("checked date not known");
endmodule

bind getf_top getf_props #(.TICK_CYCLES(TICK_CYCLES)) u_getf_props (.i_ref_clk, .i_resetn, .o_tick, .o_epoch,
  .o_report, .o_sentence, .o_report_valid);

//--- getf_host.sv
// Host model that collects time reports
`timescale 1ns/1ps
module getf_host (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_resetn,
  input  wire logic                   i_report_valid,
  input  wire getf_pkg::getf_report_s i_report,
  output getf_pkg::getf_report_s      o_last,
  output logic [7:0]                  o_count,
  output logic                        o_bad
);
  // minute length
  // Second 60 is legal, so minutes of 59 or 61 seconds parse
  always_ff @(posedge i_ref_clk or negedge i_resetn)
    if (!i_resetn)
    begin
      o_last  <= '0;
      o_count <= 8'h00;
      o_bad   <= 1'b0;
    end
    else if (i_report_valid)
    begin
      o_last  <= i_report;
      o_count <= o_count + 8'h01;
      o_bad   <= o_bad | (i_report.utc.sec > 6'h3C);
    end
endmodule

//--- test_getf_top.sv
// Bench of the epoch time formatter
`timescale 1ns/1ps
`include "getf_params.svh"
module test_getf_top;
  logic                     i_ref_clk = 1'b0;
  logic                     i_resetn = 1'b0;
  logic [7:0]               i_addr = 8'h00;
  logic [31:0]              i_wdata = 32'h0;
  logic                     i_wr = 1'b0;
  logic                     i_rd = 1'b0;
  logic [31:0]              o_rdata;
  logic                     o_tick;
  logic                     o_epoch;
  logic                     o_report_valid;
  getf_pkg::getf_report_s   o_report;
  getf_pkg::getf_report_s   last;
  getf_pkg::getf_sentence_s o_sentence;
  logic [7:0]               cnt;
  logic                     bad;
  logic [10:0]              ticks = 11'h000;
  logic [10:0]              gap = 11'h000;
  int                       n_errors = 0;
  int                       total_checks = 0;

  always #4 i_ref_clk = ~i_ref_clk;

  getf_top #(.TICK_CYCLES(8)) u_getf_top (.i_ref_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .o_tick, .o_epoch, .o_report, .o_sentence, .o_report_valid);
  getf_host u_getf_host (.i_ref_clk, .i_resetn, .i_report_valid(o_report_valid), .i_report(o_report),
    .o_last(last), .o_count(cnt), .o_bad(bad));

  always @(posedge i_ref_clk)
    if (o_epoch)
    begin
      gap   <= ticks + 11'h001;
      ticks <= 11'h000;
    end
    else if (o_tick)
      ticks <= ticks + 11'h001;

////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Strobe drops at the edge, the next one starts 1 ns later
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask

  task automatic rep;
    logic [7:0] c0;
    int         i;
    c0 = cnt;
    for (i = 0; i < 9000 && cnt == c0; i++)
    begin
      @(posedge i_ref_clk);
      #1;
    end
    if (cnt == c0)
    begin
      n_errors++;
      complete_run;
    end
  endtask

////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    @(posedge i_ref_clk);
    #1;
    rd(`GETF_REG_STATUS, 32'h0);
    rd(8'hFF, 32'h0);
    wr(`GETF_REG_CHECK, 32'h7);
    wr(`GETF_REG_TOW, 32'h100);
    wr(`GETF_REG_WEEK, 32'h5);
    wr(`GETF_REG_CAL_DATE, 32'h07DB_0C1F);
    wr(`GETF_REG_CAL_TIME, 32'hC017_3B3A);
    wr(`GETF_REG_SUBSEC, 32'h3B90_1BA0);
    wr(`GETF_REG_CTRL, 32'h11);
    rd(`GETF_REG_CTRL, 32'h11);
    rd(`GETF_REG_WEEK_RD, 32'h5);
    rep;
    chk(last.utc, {12'h7DC, 4'h1, 5'h01, 5'h00, 6'h00, 6'h00});
    chk({last.nano}, 32'hFFF5_51A0);
    chk(last.week, 16'h0005);
    chk(last.centisec, 7'h00);
    chk(last.flags & 6'h3D, 6'h00);
    chk(last.epoch_week_time_stamp, 32'h4E8);
    chk(o_sentence, {"000000.00 ", 4'h9});
    wr(`GETF_REG_BCAST_LEAP, 32'h8000_0000);
    wr(`GETF_REG_LEAP_PEND, 32'h1);
    wr(`GETF_REG_SUBSEC, 32'h1F0D_D440);
    wr(`GETF_REG_CTRL, 32'h13);
    rep;
    chk(last.utc, {12'h7DB, 4'hC, 5'h1F, 5'h17, 6'h3B, 6'h3C});
    chk(last.nano, 32'sh1F0D_D440);
    chk(last.centisec, 7'h34);
    chk(last.flags, 6'h3F);
    chk(last.epoch_week_time_stamp, 32'h8D0);
    chk(o_sentence, {"235960.520", 4'hA});
    chk(gap, 11'h3E8);
    wr(`GETF_REG_LEAP_PEND, 32'h6);
    wr(`GETF_REG_CAL_DATE, 32'h07DF_061E);
    wr(`GETF_REG_CAL_TIME, 32'hC017_3B39);
    wr(`GETF_REG_SUBSEC, 32'h0);
    wr(`GETF_REG_BIAS, 32'h0009_27C0);
    wr(`GETF_REG_CTRL, 32'h11);
    rep;
    chk(o_sentence, {"235958.00 ", 4'h9});
    rep;
    chk(last.utc, {12'h7DF, 4'h7, 5'h01, 5'h00, 6'h00, 6'h00});
    chk(gap, 11'h3E9);
    wr(`GETF_REG_BIAS, 32'hFFF6_D840);
    wr(`GETF_REG_CTRL, 32'h15);
    rep;
    chk(last.flags & 6'h3D, 6'h00);
    rep;
    chk(gap, 11'h3E7);
    chk(bad, 1'b0);
    // Time base without leap count still resolves whole seconds
    wr(`GETF_REG_CTRL, 32'h1D);
    rd(`GETF_REG_STATUS, 32'h3);
    complete_run;
  end
endmodule
